// ==== common/tcap_pkg.sv ====
package tcap_pkg;

  localparam int TCAP_PORTS       = 3;
  localparam int TCAP_CLK_NS      = 20;
  // Quiet time after any mode or polarity change
  localparam int TCAP_SETTLE_NS   = 1000;
  localparam int TCAP_SETTLE_CYC  = (TCAP_SETTLE_NS + TCAP_CLK_NS - 1) / TCAP_CLK_NS;
  localparam int TCAP_SETTLE_W    = 8;

  localparam logic TCAP_POL_HIGH  = 1'b1;
  localparam logic TCAP_EN_RST    = 1'b0;
  localparam logic TCAP_MODE2_SEL = 1'b1;

  typedef enum logic [1:0] {
    TCAP_MODE_EXT,
    TCAP_MODE_INT1,
    TCAP_MODE_INT2
  } tcap_mode_t;

  // Active level of a pin as seen through the polarity strap
  function automatic logic tcap_active(input logic lvl, input logic pol);
    tcap_active = (pol == TCAP_POL_HIGH) ? lvl : ~lvl;
  endfunction : tcap_active

endpackage : tcap_pkg

// ==== design/tcap_attach_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Three configurations: external mux, internal mux mode 1, internal mux mode 2.
// - External mux: per-port attach input gates PHY clocking while active.
// - Mux-mode select low or floating chooses internal mode 1.
// - Mode 1: attach plus orientation input give validity and cable orientation.
// - Mux-mode select high chooses internal mode 2.
// - Mode 2: lane A and lane B attach inputs give validity and orientation.
// - Internal modes enable the matching lane PHY only; unused PHYs stay off.
// - Polarity-select input sets active level of attach and orientation inputs.
module tcap_attach_ctrl
  import tcap_pkg::*;
#(
  parameter int PORTS = TCAP_PORTS
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             external_mux_select,
  input  wire logic             mux_mode_select,
  input  wire logic             attach_polarity_select,
  input  wire logic [PORTS-1:0] port_attach_in,
  input  wire logic [PORTS-1:0] port_orientation_in,
  input  wire logic [PORTS-1:0] lane_a_attach_in,
  input  wire logic [PORTS-1:0] lane_b_attach_in,
  output logic      [PORTS-1:0] phy_clock_en,
  output logic      [PORTS-1:0] phy_lane_a_en,
  output logic      [PORTS-1:0] phy_lane_b_en,
  output logic      [PORTS-1:0] attach_valid,
  output logic      [PORTS-1:0] orientation_b,
  output tcap_mode_t            mode_active
);

  localparam int SW = 3 + 4 * PORTS;

  typedef struct packed {
    tcap_mode_t               mode;
    logic                     pol;
    logic [TCAP_SETTLE_W-1:0] settle;
    logic [PORTS-1:0]         clk_en;
    logic [PORTS-1:0]         lane_a;
    logic [PORTS-1:0]         lane_b;
    logic [PORTS-1:0]         valid;
    logic [PORTS-1:0]         orient;
  } tcap_state_t;

  tcap_state_t      state_q;
  tcap_state_t      state_d;
  logic [SW-1:0]    raw_in;
  logic [SW-1:0]    syn_in;
  logic             ext_s;
  logic             msel_s;
  logic             pol_s;
  logic [PORTS-1:0] att_s;
  logic [PORTS-1:0] ori_s;
  logic [PORTS-1:0] la_s;
  logic [PORTS-1:0] lb_s;
  tcap_mode_t       mode_now;
  logic             cfg_moved;

  // External mux strap outranks the internal mode strap
  function automatic tcap_mode_t tcap_mode_of(
    input logic ext,
    input logic msel
  );
    tcap_mode_t m;
    if (ext) begin
      m = TCAP_MODE_EXT;
    end else if (msel == TCAP_MODE2_SEL) begin
      m = TCAP_MODE_INT2;
    end else begin
      // Pulled low on board when left open
      m = TCAP_MODE_INT1;
    end
    tcap_mode_of = m;
  endfunction : tcap_mode_of

  // Per-port lane claim as {lane A, lane B}; never both set
  function automatic logic [1:0] tcap_lanes(
    input tcap_mode_t mode,
    input logic       pol,
    input logic       att,
    input logic       ori,
    input logic       la,
    input logic       lb
  );
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    unique case (mode)
      TCAP_MODE_EXT: begin
        // Orientation means nothing behind an external mux
        a = tcap_active(att, pol);
      end
      TCAP_MODE_INT1: begin
        a = tcap_active(att, pol) & ~tcap_active(ori, pol);
        b = tcap_active(att, pol) & tcap_active(ori, pol);
      end
      TCAP_MODE_INT2: begin
        // Both lanes claimed: A wins, one PHY only
        a = tcap_active(la, pol);
        b = tcap_active(lb, pol) & ~a;
      end
      default: begin
        a = 1'b0;
        b = 1'b0;
      end
    endcase
    tcap_lanes = {a, b};
  endfunction : tcap_lanes

  // One port's {clock enable, lane A enable, lane B enable}
  function automatic logic [2:0] tcap_enables(
    input tcap_mode_t mode,
    input logic       a,
    input logic       b
  );
    logic [2:0] en;
    if (mode == TCAP_MODE_EXT) begin
      // External mux owns the lanes; only the clock gate is ours
      en = {a, TCAP_EN_RST, TCAP_EN_RST};
    end else begin
      en = {a | b, a, b};
    end
    tcap_enables = en;
  endfunction : tcap_enables

  // Drop every PHY and start the quiet window, so no lane
  // sees a half-decoded attach from the old mode
  function automatic tcap_state_t tcap_cleared(
    input tcap_mode_t mode,
    input logic       pol
  );
    tcap_state_t s;
    s            = '0;
    s.mode       = mode;
    s.pol        = pol;
    s.settle     = TCAP_SETTLE_W'(TCAP_SETTLE_CYC);
    tcap_cleared = s;
  endfunction : tcap_cleared

  // Straps and attach pins share one synchroniser, so a polarity
  // flip and the re-levelled pins arrive in the same cycle
  assign raw_in = {external_mux_select, mux_mode_select, attach_polarity_select,
                   port_attach_in, port_orientation_in, lane_a_attach_in, lane_b_attach_in};

  tcap_sync #(.W(SW)) u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  assign {ext_s, msel_s, pol_s, att_s, ori_s, la_s, lb_s} = syn_in;

  assign mode_now  = tcap_mode_of(ext_s, msel_s);
  assign cfg_moved = (mode_now != state_q.mode) || (pol_s != state_q.pol);

  always_comb begin
    logic a;
    logic b;
    a       = 1'b0;
    b       = 1'b0;
    state_d = state_q;
    if (cfg_moved) begin
      state_d = tcap_cleared(mode_now, pol_s);
    end else if (state_q.settle != '0) begin
      // Outputs stay dark until the straps have been quiet a while
      state_d.settle = state_q.settle - TCAP_SETTLE_W'(1);
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        // Decode uses the registered mode and polarity, never the
        // freshly synchronised straps, so a port never mixes two modes
        {a, b} = tcap_lanes(
          state_q.mode,
          state_q.pol,
          att_s[p],
          ori_s[p],
          la_s[p],
          lb_s[p]
        );
        state_d.valid[p]  = a | b;
        state_d.orient[p] = b;
        {state_d.clk_en[p], state_d.lane_a[p], state_d.lane_b[p]} =
          tcap_enables(state_q.mode, a, b);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign phy_clock_en  = state_q.clk_en;
  assign phy_lane_a_en = state_q.lane_a;
  assign phy_lane_b_en = state_q.lane_b;
  assign attach_valid  = state_q.valid;
  assign orientation_b = state_q.orient;
  assign mode_active   = state_q.mode;

endmodule : tcap_attach_ctrl
`default_nettype wire

// ==== design/tcap_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcap_sync
  import tcap_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } tcap_sync_state_t;

  tcap_sync_state_t state_q;
  tcap_sync_state_t state_d;

  // First stage feeds only the second stage
  always_comb begin
    state_d      = state_q;
    state_d.meta = async_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.sync;

endmodule : tcap_sync
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcap_pkg::*;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic       external_mux_select = 1'b1;
  logic       mux_mode_select = 1'b0;
  logic       attach_polarity_select = 1'b1;
  logic [2:0] port_attach_in, port_orientation_in, lane_a_attach_in, lane_b_attach_in;
  logic [2:0] phy_clock_en, phy_lane_a_en, phy_lane_b_en, attach_valid, orientation_b;
  tcap_mode_t mode_active;
  int         err_count = 0;
  int         compares = 0;
  int         cyc = 0;
  tcap_pc_model i_pc (.*);
  tcap_attach_ctrl i_dut (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [2:0] e, input logic [2:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cfg(input logic e, input logic m, input logic p);
    @(posedge clk_sys);
    external_mux_select <= e;
    mux_mode_select <= m;
    attach_polarity_select <= p;
    repeat (70) @(posedge clk_sys);
    #1;
  endtask : cfg
  task automatic put(input logic [11:0] v);
    i_pc.show(v);
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : put
  task automatic t_ext();
    cfg(1'b1, 1'b0, 1'b1);
    put(12'hA9E);
    chk(3'h5, phy_clock_en);
    chk(3'h5, attach_valid);
    chk(3'(TCAP_MODE_EXT), 3'(mode_active));
    chk(3'h0, phy_lane_a_en | phy_lane_b_en);
    cfg(1'b1, 1'b0, 1'b0);
    chk(3'h5, phy_clock_en);
    put(12'h000);
    chk(3'h0, phy_clock_en);
  endtask : t_ext
  task automatic t_m1();
    cfg(1'b0, 1'b0, 1'b1);
    put(12'hE9E);
    chk(3'(TCAP_MODE_INT1), 3'(mode_active));
    chk(3'h5, phy_lane_a_en);
    chk(3'h2, phy_lane_b_en);
    chk(3'h2, orientation_b);
  endtask : t_m1
  task automatic t_m2();
    cfg(1'b0, 1'b1, 1'b0);
    chk(3'(TCAP_MODE_INT2), 3'(mode_active));
    chk(3'h3, phy_lane_a_en);
    chk(3'h4, phy_lane_b_en);
    chk(3'h7, phy_clock_en);
  endtask : t_m2
  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_ext();
    t_m1();
    t_m2();
    close_out();
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end
endmodule : tb
`default_nettype wire

// ==== verification/tcap_attach_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcap_attach_ctrl_asserts
  import tcap_pkg::*;
#(parameter int PORTS = TCAP_PORTS) (
  input wire logic             clk_sys,
  input wire logic             arst_n,
  input wire logic             external_mux_select,
  input wire logic             mux_mode_select,
  input wire logic             attach_polarity_select,
  input wire logic [PORTS-1:0] port_attach_in,
  input wire logic [PORTS-1:0] port_orientation_in,
  input wire logic [PORTS-1:0] lane_a_attach_in,
  input wire logic [PORTS-1:0] lane_b_attach_in,
  input wire logic [PORTS-1:0] phy_clock_en,
  input wire logic [PORTS-1:0] phy_lane_a_en,
  input wire logic [PORTS-1:0] phy_lane_b_en,
  input wire logic [PORTS-1:0] attach_valid,
  input wire logic [PORTS-1:0] orientation_b,
  input wire tcap_mode_t       mode_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [6:0] q;
  logic [2:0] cfg_q;
  wire [2:0] cfg = {external_mux_select, mux_mode_select, attach_polarity_select};
  wire [PORTS-1:0] inv = {PORTS{~attach_polarity_select}};
  wire [PORTS-1:0] at = port_attach_in ^ inv;
  wire [PORTS-1:0] ot = port_orientation_in ^ inv;
  wire [PORTS-1:0] la = lane_a_attach_in ^ inv;
  wire [PORTS-1:0] lb = lane_b_attach_in ^ inv;
  wire [4*PORTS-1:0] ins = {port_attach_in, port_orientation_in, lane_a_attach_in, lane_b_attach_in};
  wire calm = cfg == cfg_q;
  // Past the settle window only
  wire ok = calm && q > 7'h3C;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= 7'h00;
      cfg_q <= 3'h0;
    end else begin
      cfg_q <= cfg;
      q <= (cfg != cfg_q) ? 7'h00 : (q == 7'h7F) ? q : q + 7'h01;
    end
  end
  a_ext_lanes_off: assert property (mode_active == TCAP_MODE_EXT |-> !(phy_lane_a_en | phy_lane_b_en))
    else $error("lane on in ext mode");
  a_clk_lanes: assert property (mode_active != TCAP_MODE_EXT |-> phy_clock_en == (phy_lane_a_en | phy_lane_b_en))
    else $error("clock not lane or");
  a_valid_clk: assert property (phy_clock_en == attach_valid)
    else $error("clock differs from valid");
  a_mode_sel: assert property (calm && q > 7'h05 |-> mode_active == (external_mux_select ? TCAP_MODE_EXT
    : mux_mode_select ? TCAP_MODE_INT2 : TCAP_MODE_INT1)) else $error("wrong mode");
  a_ext_decode: assert property ($stable(ins)[*4] ##0 (ok && external_mux_select) |-> attach_valid == at)
    else $error("ext decode");
  a_m1_decode: assert property ($stable(ins)[*4] ##0 (ok && !external_mux_select && !mux_mode_select) |->
    phy_lane_a_en == (at & ~ot) && phy_lane_b_en == (at & ot) && orientation_b == (at & ot))
    else $error("mode 1 decode");
  a_m2_decode: assert property ($stable(ins)[*4] ##0 (ok && !external_mux_select && mux_mode_select) |->
    phy_lane_a_en == la && phy_lane_b_en == (lb & ~la)) else $error("mode 2 decode");
  a_settle_quiet: assert property ($changed(attach_polarity_select) |-> ##4 (attach_valid == '0)[*8])
    else $error("no settle");
endmodule : tcap_attach_ctrl_asserts
bind tcap_attach_ctrl tcap_attach_ctrl_asserts #(.PORTS(PORTS)) i_chk (.*);
`default_nettype wire

// ==== verification/tcap_pc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcap_pc_model (
  input  wire logic       clk_sys,
  input  wire logic       attach_polarity_select,
  output logic      [2:0] port_attach_in,
  output logic      [2:0] port_orientation_in,
  output logic      [2:0] lane_a_attach_in,
  output logic      [2:0] lane_b_attach_in
);
  logic [11:0] lv_q = 12'h000;
  // Pins follow the strap at once, as a real controller wired to it would
  assign {port_attach_in, port_orientation_in, lane_a_attach_in, lane_b_attach_in} =
    lv_q ^ {12{~attach_polarity_select}};
  task automatic show(input logic [11:0] v);
    @(posedge clk_sys);
    lv_q <= v;
  endtask : show
endmodule : tcap_pc_model
`default_nettype wire
